/* File: common/ismx_map.vh */
// Constants for the immediate-shift plus memory-move execute block
`ifndef ISMX_MAP_VH
`define ISMX_MAP_VH
`define ISMX_COND_ALWAYS 5'h1f
`define ISMX_WIDTH_NW 2'h0
`define ISMX_WIDTH_SW 2'h1
`define ISMX_WIDTH_BW 2'h2
`define ISMX_K_NW 32'h00000001
`define ISMX_K_SW 32'h00000002
`define ISMX_K_BW 32'h00000004
`define ISMX_OP_LSHIFT 3'h0
`define ISMX_OP_ASHIFT 3'h1
`define ISMX_OP_ROT 3'h2
`define ISMX_OP_FEXT 3'h3
`define ISMX_OP_FDEP 3'h4
`define ISMX_ST_IDLE 2'h0
`define ISMX_ST_EXEC 2'h1
`endif

/* File: core/ismx_shifter.v */
// Immediate shifter: one register operand, immediate Y operand, registered result
`timescale 1ns/1ps
`default_nettype none
`include "ismx_map.vh"
module ismx_shifter #(
   parameter DW = 32
) (
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // Operation
   input wire [2:0] op,
   input wire [DW-1:0] x_operand,
   input wire [7:0] imm8,
   input wire [5:0] imm_len,
   input wire [5:0] imm_pos,
   // Result
   output reg [DW-1:0] result_ff
);
   wire signed [7:0] amt = $signed(imm8);
   wire [7:0] mag = amt[7] ? (~imm8 + 8'h01) : imm8;
   wire [DW-1:0] field_mask = ~({DW{1'b1}} << imm_len);
   // Kept apart from the case so an unsigned context cannot turn it into a logical shift
   wire signed [DW-1:0] x_signed = x_operand;
   wire [DW-1:0] asr_val = x_signed >>> mag;
   reg [DW-1:0] nxt_result;
   always @* begin
      nxt_result = {DW{1'b0}};
      case (op)
         `ISMX_OP_LSHIFT: nxt_result = amt[7] ? (x_operand >> mag) : (x_operand << mag);
         `ISMX_OP_ASHIFT: nxt_result = amt[7] ? asr_val : (x_operand << mag);
         `ISMX_OP_ROT: nxt_result = (x_operand << mag[4:0]) | (x_operand >> (6'd32 - {1'b0, mag[4:0]}));
         `ISMX_OP_FEXT: nxt_result = (x_operand >> imm_pos) & field_mask;
         `ISMX_OP_FDEP: nxt_result = (x_operand & field_mask) << imm_pos;
         default: nxt_result = x_operand;
      endcase
   end
   always @(posedge clk) begin
      if (!rst_n) begin
         result_ff <= {DW{1'b0}};
      end else begin
         result_ff <= nxt_result;
      end
   end
endmodule
`default_nettype wire

/* File: core/ismx_exec.v */
// Execute stage for the immediate shift with optional memory move
`timescale 1ns/1ps
`default_nettype none
`include "ismx_map.vh"
module ismx_exec #(
   parameter DW = 32,
   parameter AW = 32,
   parameter RW = 4
) (
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // Decoded instruction
   input wire issue,
   input wire [4:0] cond_code,
   input wire [2:0] shift_op,
   input wire [7:0] imm8,
   input wire [5:0] imm_len,
   input wire [5:0] imm_pos,
   input wire [RW-1:0] src_reg,
   input wire [RW-1:0] dst_reg,
   input wire [RW-1:0] xfer_reg,
   input wire has_mem,
   input wire mem_sel,
   input wire dir_write,
   input wire [1:0] access_width,
   // Mode bits
   input wire simd_mode,
   input wire broadcast_read_gen_one,
   input wire broadcast_read_gen_two,
   input wire gen_one_broadcast_index,
   input wire gen_two_broadcast_index,
   // Condition results from each element's flags
   input wire primary_cond_true,
   input wire secondary_cond_true,
   // Register file read data
   input wire [DW-1:0] prim_x_data,
   input wire [DW-1:0] sec_x_data,
   input wire [DW-1:0] prim_xfer_data,
   input wire [DW-1:0] sec_xfer_data,
   // Address generator values
   input wire [AW-1:0] index_value,
   input wire [AW-1:0] modifier_value,
   // Memory read data
   input wire [DW-1:0] prim_rd_data,
   input wire [DW-1:0] sec_rd_data,
   // Register file write back
   output reg prim_sh_we_ff,
   output reg sec_sh_we_ff,
   output reg [RW-1:0] sh_wr_reg_ff,
   output wire [DW-1:0] prim_sh_data,
   output wire [DW-1:0] sec_sh_data,
   output reg prim_ld_we_ff,
   output reg sec_ld_we_ff,
   output reg [RW-1:0] ld_wr_reg_ff,
   output reg [DW-1:0] prim_ld_data_ff,
   output reg [DW-1:0] sec_ld_data_ff,
   // Memory access, primary element
   output reg prim_mem_req_ff,
   output reg prim_mem_we_ff,
   output reg prim_mem_pm_ff,
   output reg [AW-1:0] prim_mem_addr_ff,
   output reg [DW-1:0] prim_mem_wdata_ff,
   // Memory access, secondary element
   output reg sec_mem_req_ff,
   output reg sec_mem_we_ff,
   output reg sec_mem_pm_ff,
   output reg [AW-1:0] sec_mem_addr_ff,
   output reg [DW-1:0] sec_mem_wdata_ff,
   // Index write back to the selected generator
   output reg idx_we_ff,
   output reg idx_gen_two_ff,
   output reg [AW-1:0] idx_wdata_ff
);
   //-------------------------------------------
   // Condition and offset decode
   //-------------------------------------------
   function cond_pass;
      input [4:0] code;
      input flag_true;
      begin
         cond_pass = (code == `ISMX_COND_ALWAYS) | flag_true;
      end
   endfunction

   function [AW-1:0] simd_offset;
      input [1:0] width;
      begin
         case (width)
            `ISMX_WIDTH_NW: simd_offset = `ISMX_K_NW;
            `ISMX_WIDTH_SW: simd_offset = `ISMX_K_SW;
            `ISMX_WIDTH_BW: simd_offset = `ISMX_K_BW;
            default: simd_offset = `ISMX_K_NW;
         endcase
      end
   endfunction

   wire prim_go = issue & cond_pass(cond_code, primary_cond_true);
   wire sec_go = issue & simd_mode & cond_pass(cond_code, secondary_cond_true);
   // Broadcast applies to reads only, through the generator's broadcast index
   wire bcast = ~dir_write & (mem_sel ? (broadcast_read_gen_two & gen_two_broadcast_index) :
                (broadcast_read_gen_one & gen_one_broadcast_index));
   wire [AW-1:0] sec_addr = bcast ? index_value : (index_value + simd_offset(access_width));
   wire mem_on = has_mem;

   //-------------------------------------------
   // Pipeline state: the shift result lands one edge after issue
   //-------------------------------------------
   reg pending_ld_ff;
   reg bcast_ff;

   ismx_shifter #(.DW(DW)) u_prim_sh (
      .clk(clk),
      .rst_n(rst_n),
      .op(shift_op),
      .x_operand(prim_x_data),
      .imm8(imm8),
      .imm_len(imm_len),
      .imm_pos(imm_pos),
      .result_ff(prim_sh_data)
   );

   ismx_shifter #(.DW(DW)) u_sec_sh (
      .clk(clk),
      .rst_n(rst_n),
      .op(shift_op),
      .x_operand(sec_x_data),
      .imm8(imm8),
      .imm_len(imm_len),
      .imm_pos(imm_pos),
      .result_ff(sec_sh_data)
   );

   //-------------------------------------------
   // Issue: shift write enables and memory requests in the same edge
   //-------------------------------------------
   always @(posedge clk) begin
      if (!rst_n) begin
         prim_sh_we_ff <= 1'b0;
         sec_sh_we_ff <= 1'b0;
         sh_wr_reg_ff <= {RW{1'b0}};
         prim_mem_req_ff <= 1'b0;
         prim_mem_we_ff <= 1'b0;
         prim_mem_pm_ff <= 1'b0;
         prim_mem_addr_ff <= {AW{1'b0}};
         prim_mem_wdata_ff <= {DW{1'b0}};
         sec_mem_req_ff <= 1'b0;
         sec_mem_we_ff <= 1'b0;
         sec_mem_pm_ff <= 1'b0;
         sec_mem_addr_ff <= {AW{1'b0}};
         sec_mem_wdata_ff <= {DW{1'b0}};
         idx_we_ff <= 1'b0;
         idx_gen_two_ff <= 1'b0;
         idx_wdata_ff <= {AW{1'b0}};
         pending_ld_ff <= 1'b0;
         bcast_ff <= 1'b0;
         ld_wr_reg_ff <= {RW{1'b0}};
      end else begin
         prim_sh_we_ff <= prim_go;
         sec_sh_we_ff <= sec_go;
         sh_wr_reg_ff <= dst_reg;
         prim_mem_req_ff <= prim_go & mem_on;
         prim_mem_we_ff <= dir_write;
         prim_mem_pm_ff <= mem_sel;
         prim_mem_addr_ff <= index_value;
         prim_mem_wdata_ff <= prim_xfer_data;
         // A broadcast read is one word for both elements, so no second request
         sec_mem_req_ff <= sec_go & mem_on & ~bcast;
         sec_mem_we_ff <= dir_write;
         sec_mem_pm_ff <= mem_sel;
         sec_mem_addr_ff <= sec_addr;
         sec_mem_wdata_ff <= sec_xfer_data;
         // Either element may move the shared index; secondary adds no modifier
         idx_we_ff <= (prim_go | sec_go) & mem_on;
         idx_gen_two_ff <= mem_sel;
         idx_wdata_ff <= index_value + modifier_value;
         pending_ld_ff <= (prim_go | sec_go) & mem_on & ~dir_write;
         bcast_ff <= bcast;
         ld_wr_reg_ff <= xfer_reg;
      end
   end

   //-------------------------------------------
   // Load return: memory answers in the request's cycle; the data is registered one edge after the request
   //-------------------------------------------
   always @(posedge clk) begin
      if (!rst_n) begin
         prim_ld_we_ff <= 1'b0;
         sec_ld_we_ff <= 1'b0;
         prim_ld_data_ff <= {DW{1'b0}};
         sec_ld_data_ff <= {DW{1'b0}};
      end else begin
         prim_ld_we_ff <= pending_ld_ff & prim_mem_req_ff & ~prim_mem_we_ff;
         sec_ld_we_ff <= pending_ld_ff & ~sec_mem_we_ff &
                         (sec_mem_req_ff | (bcast_ff & prim_mem_req_ff & sec_sh_we_ff));
         prim_ld_data_ff <= prim_rd_data;
         sec_ld_data_ff <= bcast_ff ? prim_rd_data : sec_rd_data;
      end
   end
endmodule
`default_nettype wire

/* File: dv/ismx_mem_model.sv */
// Memory stand-in that answers reads in the same cycle as the request
`timescale 1ns/1ps
`default_nettype none
module ismx_mem_model #(parameter DW = 32, parameter AW = 32) (
   // Clock and request
   input wire logic clk,
   input wire logic req,
   input wire logic [AW-1:0] addr,
   // Read data
   output logic [DW-1:0] rd_data
);
   logic [DW-1:0] idle_ff = 32'h0;
   // Unselected bus toggles so a stale word never passes as fresh data
   always @(posedge clk) idle_ff <= ~idle_ff;
   assign rd_data = req ? (DW'(addr) ^ 32'h5a5a0000) : idle_ff;
endmodule
`default_nettype wire

/* File: dv/ismx_exec_sva.sv */
// Checker for the immediate-shift execute block, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module ismx_exec_sva #(parameter DW = 32, parameter AW = 32, parameter RW = 4) (
   // Clock, reset and instruction
   input wire logic clk, rst_n, issue, has_mem, mem_sel, dir_write, simd_mode,
   input wire logic primary_cond_true, secondary_cond_true,
   input wire logic [4:0] cond_code,
   input wire logic [1:0] access_width,
   input wire logic [RW-1:0] dst_reg,
   input wire logic [AW-1:0] index_value, modifier_value,
   input wire logic [DW-1:0] prim_rd_data,
   // Results
   input wire logic prim_sh_we_ff, sec_sh_we_ff, prim_ld_we_ff, idx_we_ff,
   input wire logic prim_mem_req_ff, prim_mem_we_ff, prim_mem_pm_ff, sec_mem_req_ff,
   input wire logic [RW-1:0] sh_wr_reg_ff,
   input wire logic [DW-1:0] prim_ld_data_ff,
   input wire logic [AW-1:0] prim_mem_addr_ff, sec_mem_addr_ff, idx_wdata_ff
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire logic always_c = (cond_code == 5'h1f);
   wire logic p_ok = issue && (always_c || primary_cond_true);
   wire logic s_ok = issue && simd_mode && (always_c || secondary_cond_true);
   wire logic [2:0] k_sel = (access_width == 2'h1) ? 3'h2 : (access_width == 2'h2) ? 3'h4 : 3'h1;
   chk_cond_always: assert property (issue && always_c |=> prim_sh_we_ff)
      else $error("unconditional shift not written");
   chk_cond_fail: assert property (issue && !p_ok |=> !prim_sh_we_ff && !prim_mem_req_ff)
      else $error("failed condition still acted");
   chk_sisd_quiet: assert property (issue && !simd_mode |=> !sec_sh_we_ff && !sec_mem_req_ff)
      else $error("secondary acted outside simd");
   chk_result_reg: assert property (p_ok |=> sh_wr_reg_ff == $past(dst_reg))
      else $error("shift result register wrong");
   chk_post_modify: assert property (has_mem && (p_ok || s_ok) |=> idx_we_ff &&
      idx_wdata_ff == $past(index_value) + $past(modifier_value)) else $error("index update wrong");
   chk_prim_access: assert property (p_ok && has_mem |=> prim_mem_req_ff &&
      prim_mem_addr_ff == $past(index_value) && prim_mem_we_ff == $past(dir_write) &&
      prim_mem_pm_ff == $past(mem_sel)) else $error("primary access wrong");
   chk_sec_offset: assert property (s_ok && has_mem && dir_write |=> sec_mem_req_ff &&
      sec_mem_addr_ff == $past(index_value) + AW'($past(k_sel))) else $error("secondary offset");
   chk_no_mem: assert property (issue && !has_mem |=> !prim_mem_req_ff && !idx_we_ff)
      else $error("memory-less variant touched memory");
   chk_load_same: assert property (prim_mem_req_ff && !prim_mem_we_ff |=> prim_ld_we_ff &&
      prim_ld_data_ff == $past(prim_rd_data)) else $error("load data wrong");
   cover property (s_ok && has_mem && !dir_write);
   cover property (issue && !has_mem);
   cover property (prim_ld_we_ff);
endmodule
bind ismx_exec ismx_exec_sva #(.DW(DW), .AW(AW), .RW(RW)) u_ismx_exec_sva (.*);
`default_nettype wire

/* File: dv/ismx_exec_bench.sv */
// Self-checking bench for the immediate-shift execute block
`timescale 1ns/1ps
`default_nettype none
module ismx_exec_bench;
   logic clk = 1'b0, rst_n = 1'b0, issue = 1'b0, has_mem = 1'b0, mem_sel = 1'b0;
   logic dir_write = 1'b0, simd_mode = 1'b0, primary_cond_true = 1'b0, secondary_cond_true = 1'b0;
   logic broadcast_read_gen_one = 1'b0, broadcast_read_gen_two = 1'b0;
   logic gen_one_broadcast_index = 1'b0, gen_two_broadcast_index = 1'b0;
   logic [4:0] cond_code = 5'h1f;
   logic [2:0] shift_op = 3'h0;
   logic [7:0] imm8 = 8'h04;
   logic [5:0] imm_len = 6'h00, imm_pos = 6'h00;
   logic [3:0] src_reg = 4'h6, dst_reg = 4'h2, xfer_reg = 4'h0;
   logic [1:0] access_width = 2'h0;
   logic [31:0] prim_x_data = 32'h13, sec_x_data = 32'h21, prim_xfer_data = 32'hcafe0001;
   logic [31:0] sec_xfer_data = 32'hbeef0002, index_value = 32'h100, modifier_value = 32'h10;
   wire logic prim_sh_we_ff, sec_sh_we_ff, prim_ld_we_ff, sec_ld_we_ff, idx_we_ff, idx_gen_two_ff;
   wire logic prim_mem_req_ff, prim_mem_we_ff, prim_mem_pm_ff;
   wire logic sec_mem_req_ff, sec_mem_we_ff, sec_mem_pm_ff;
   wire logic [3:0] sh_wr_reg_ff, ld_wr_reg_ff;
   wire logic [31:0] prim_sh_data, sec_sh_data, prim_ld_data_ff, sec_ld_data_ff, idx_wdata_ff;
   wire logic [31:0] prim_mem_addr_ff, prim_mem_wdata_ff, sec_mem_addr_ff, sec_mem_wdata_ff;
   wire logic [31:0] prim_rd_data, sec_rd_data;
   int n_errors = 0;
   int checked = 0;
   ismx_exec u_ismx_exec (.*);
   ismx_mem_model u_ismx_mem_model (.clk(clk), .req(prim_mem_req_ff), .addr(prim_mem_addr_ff),
      .rd_data(prim_rd_data));
   ismx_mem_model u_ismx_mem_model_sec (.clk(clk), .req(sec_mem_req_ff), .addr(sec_mem_addr_ff),
      .rd_data(sec_rd_data));
   always #12.5 clk = ~clk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Issue held for exactly one sampling edge; shift results and memory requests are visible on return, load data one edge later
   task automatic fire;
      @(posedge clk) #2 issue = 1'b1;
      @(posedge clk) #2 issue = 1'b0;
   endtask
   task automatic t_shift_only;
      fire;
      chk(prim_sh_we_ff, 1);
      chk(prim_sh_data, 32'h130);
      chk(sh_wr_reg_ff, 4'h2);
      chk(idx_we_ff | prim_mem_req_ff, 0);
      chk(sec_sh_we_ff, 0);
   endtask
   task automatic t_simd_store;
      int k;
      {has_mem, dir_write, mem_sel, simd_mode, secondary_cond_true} = 5'h1f;
      cond_code = 5'h03;
      for (int w = 0; w < 3; w++) begin
         k = (w == 0) ? 1 : (w == 1) ? 2 : 4;
         access_width = w[1:0];
         fire;
         chk(prim_mem_req_ff | prim_sh_we_ff, 0);
         chk(sec_mem_req_ff, 1);
         chk(sec_mem_addr_ff, 32'h100 + k);
         chk({sec_mem_pm_ff, idx_gen_two_ff, sec_mem_we_ff}, 3'h7);
         chk(sec_mem_wdata_ff, 32'hbeef0002);
         chk(prim_mem_wdata_ff, 32'hcafe0001);
         chk(idx_wdata_ff, 32'h110);
         chk(sec_sh_data, 32'h210);
      end
   endtask
   task automatic t_bcast_load;
      {dir_write, mem_sel, broadcast_read_gen_one, gen_one_broadcast_index} = 4'h3;
      cond_code = 5'h1f;
      access_width = 2'h0;
      xfer_reg = 4'h5;
      fire;
      chk(sec_mem_req_ff, 0);
      chk(prim_mem_addr_ff, 32'h100);
      @(posedge clk) #2;
      chk({prim_ld_we_ff, sec_ld_we_ff}, 2'h3);
      chk(prim_ld_data_ff, 32'h5a5a0100);
      chk(sec_ld_data_ff, 32'h5a5a0100);
      chk(ld_wr_reg_ff, 4'h5);
   endtask
   task automatic t_ops;
      {has_mem, simd_mode} = 2'h0;
      shift_op = 3'h1;
      imm8 = 8'hfc;
      prim_x_data = 32'h80000010;
      fire;
      chk(prim_sh_data, 32'hf8000001);
      shift_op = 3'h3;
      imm_pos = 6'h04;
      imm_len = 6'h08;
      prim_x_data = 32'h00000ab0;
      fire;
      chk(prim_sh_data, 32'h000000ab);
      shift_op = 3'h4;
      prim_x_data = 32'h000000ab;
      fire;
      chk(prim_sh_data, 32'h00000ab0);
      chk(idx_we_ff | prim_mem_req_ff | sec_sh_we_ff, 0);
   endtask
   task automatic test_done;
      $display("errors %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge clk);
      #2 rst_n = 1'b1;
      t_shift_only;
      t_simd_store;
      t_bcast_load;
      t_ops;
      test_done;
   end
   initial begin
      #5000;
      n_errors++;
      test_done;
   end
endmodule
`default_nettype wire
